// *** split_reload_timer_cfg.svh ***
// register offsets, field positions, reset values and counts of the timer
`ifndef SPLIT_RELOAD_TIMER_CFG_SVH
`define SPLIT_RELOAD_TIMER_CFG_SVH

// special-function register addresses
`define TMR_ADDR_CONTROL 8'hC8
`define TMR_ADDR_RELOAD_LOW 8'hCA
`define TMR_ADDR_RELOAD_HIGH 8'hCB
`define TMR_ADDR_COUNT_LOW 8'hCC

// control register bit positions
`define TMR_BIT_HIGH_FLAG 7
`define TMR_BIT_LOW_FLAG 6
`define TMR_BIT_LOW_IRQ_EN 5
`define TMR_BIT_CAPTURE_EN 4
`define TMR_BIT_SPLIT 3
`define TMR_BIT_RUN 2
`define TMR_BIT_UNUSED 1
`define TMR_BIT_EXT_CLOCK 0

// reset values
`define TMR_RESET_BYTE 8'h00
`define TMR_RESET_WORD 16'h0000

// prescaler counts: system clock / 12 and external clock / 8
`define TMR_DIV12_LAST 4'hB
`define TMR_EXT_DIV8_LAST 3'h7

// rollover values
`define TMR_BYTE_ALL_ONES 8'hFF
`define TMR_WORD_ALL_ONES 16'hFFFF

`endif

// *** split_reload_timer_pkg.sv ***
// types shared by the split reload timer
package split_reload_timer_pkg;

  // counting structure, one-hot
  typedef enum logic [1:0] {
    MODE_WIDE  = 2'b01,
    MODE_SPLIT = 2'b10
  } count_mode_e;

  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;

endpackage : split_reload_timer_pkg

// *** split_reload_timer.sv ***
// split reload timer with comparator capture, reached over the sfr port
//
// What this block does
// RULE1: low byte rollover requests interrupt if low and timer irq enabled.
// RULE2: comparator rise copies 16-bit count into reload when enabled.
// RULE3: each capture raises the interrupt request if timer irq enabled.
// RULE4: split bit chooses one 16-bit counter or two 8-bit counters.
// RULE5: timer counts only while run bit is one in 16-bit mode.
// RULE6: in split mode run gates high counter; low counter always counts.
// RULE7: control bit one reads zero and ignores writes.
// RULE8: external select picks system clock over 12 or external over 8.
// RULE9: external select serves both split bytes; byte select overrides.
// RULE10: reload low and high bytes are read/write and reset to zero.
// RULE11: low count register is read/write low byte of the count.
// RULE12: 16-bit rollover loads reload pair and sets high overflow flag.
// RULE13: per-byte clock select one picks system clock, zero picks prescaled.
// RULE14: low flag set on every low rollover; hardware never clears flags.
// RULE15: in split mode each byte reloads from its own reload byte.
// RULE16: capture only when capture enabled and split mode cleared.
// RULE17: comparator is synchronised; rise seen between synced samples.
`timescale 1ns/1ps
`include "split_reload_timer_cfg.svh"

module split_reload_timer (
  // clock and reset
  input wire logic clock_in,
  input wire logic arst_n_in,
  // special-function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // system context
  input wire logic timer_irq_enable_in,
  input wire logic high_byte_clock_select_in,
  input wire logic low_byte_clock_select_in,
  input wire logic ext_osc_in,
  input wire logic capture_comparator_in,
  // results
  output logic irq_out,
  output logic [15:0] timer_count_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers and input synchronisers
  logic [3:0] div12_reg, div12_next;
  logic [2:0] ext_div_reg, ext_div_next;
  logic [2:0] ext_sync_reg, ext_sync_next;
  logic [2:0] cmp_sync_reg, cmp_sync_next;
  logic tick12, ext_edge, ext_tick, cmp_rise;

  // dividers and edge detection; sync stage 0 feeds only stage 1
  always_comb begin
    tick12 = (div12_reg == `TMR_DIV12_LAST); // [RULE8]
    div12_next = tick12 ? 4'h0 : div12_reg + 4'h1;
    ext_sync_next = {ext_sync_reg[1:0], ext_osc_in};
    ext_edge = ext_sync_reg[1] & ~ext_sync_reg[2];
    ext_tick = ext_edge && (ext_div_reg == `TMR_EXT_DIV8_LAST); // [RULE8]
    ext_div_next = ext_edge ? ext_div_reg + 3'h1 : ext_div_reg;
    cmp_sync_next = {cmp_sync_reg[1:0], capture_comparator_in}; // [RULE17]
    cmp_rise = cmp_sync_reg[1] & ~cmp_sync_reg[2]; // [RULE17]
  end

  always_ff @(posedge clock_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      div12_reg <= 4'h0;
      ext_div_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      cmp_sync_reg <= 3'h0;
    end else begin
      div12_reg <= div12_next;
      ext_div_reg <= ext_div_next;
      ext_sync_reg <= ext_sync_next;
      cmp_sync_reg <= cmp_sync_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, reload and count state
  logic flag_hi_reg, flag_hi_next;
  logic flag_lo_reg, flag_lo_next;
  logic low_irq_en_reg, low_irq_en_next;
  logic cap_en_reg, cap_en_next;
  logic split_reg, split_next;
  logic run_reg, run_next;
  logic xclk_reg, xclk_next;
  split_reload_timer_pkg::word_t reload_reg, reload_next;
  split_reload_timer_pkg::word_t count_reg, count_next;
  split_reload_timer_pkg::count_mode_e mode;
  logic base_tick, low_tick, high_tick, cap_fire, set_hi, set_lo;
  logic wr_ctrl, wr_rl_lo, wr_rl_hi, wr_cnt_lo;
  logic irq_next;

  // write decode
  assign wr_ctrl = sfr_wr_in && (sfr_addr_in == `TMR_ADDR_CONTROL);
  assign wr_rl_lo = sfr_wr_in && (sfr_addr_in == `TMR_ADDR_RELOAD_LOW);
  assign wr_rl_hi = sfr_wr_in && (sfr_addr_in == `TMR_ADDR_RELOAD_HIGH);
  assign wr_cnt_lo = sfr_wr_in && (sfr_addr_in == `TMR_ADDR_COUNT_LOW);

  // counting, capture and software writes; hardware sets beat clears
  always_comb begin
    mode = split_reg ? split_reload_timer_pkg::MODE_SPLIT
                     : split_reload_timer_pkg::MODE_WIDE; // [RULE4]
    base_tick = xclk_reg ? ext_tick : tick12; // [RULE8] [RULE9]
    low_tick = low_byte_clock_select_in | base_tick; // [RULE13]
    high_tick = high_byte_clock_select_in | base_tick; // [RULE13] [RULE9]
    cap_fire = cap_en_reg && !split_reg && cmp_rise; // [RULE16]
    set_hi = 1'b0;
    set_lo = 1'b0;
    count_next = count_reg;
    reload_next = reload_reg;
    unique case (mode)
      split_reload_timer_pkg::MODE_SPLIT: begin
        // low byte ignores run control
        if (low_tick) begin // [RULE6]
          if (count_reg[7:0] == `TMR_BYTE_ALL_ONES) begin
            count_next[7:0] = reload_reg[7:0]; // [RULE15]
            set_lo = 1'b1; // [RULE14]
          end else begin
            count_next[7:0] = count_reg[7:0] + 8'h01;
          end
        end
        if (run_reg && high_tick) begin // [RULE6]
          if (count_reg[15:8] == `TMR_BYTE_ALL_ONES) begin
            count_next[15:8] = reload_reg[15:8]; // [RULE15]
            set_hi = 1'b1;
          end else begin
            count_next[15:8] = count_reg[15:8] + 8'h01;
          end
        end
      end
      split_reload_timer_pkg::MODE_WIDE: begin
        if (run_reg && low_tick) begin // [RULE5]
          if (count_reg == `TMR_WORD_ALL_ONES) begin
            count_next = reload_reg; // [RULE12]
            set_hi = 1'b1; // [RULE12]
          end else begin
            count_next = count_reg + 16'h0001;
          end
          set_lo = (count_reg[7:0] == `TMR_BYTE_ALL_ONES); // [RULE14]
        end
      end
    endcase
    // software register writes
    if (wr_rl_lo) begin
      reload_next[7:0] = sfr_wdata_in; // [RULE10]
    end
    if (wr_rl_hi) begin
      reload_next[15:8] = sfr_wdata_in; // [RULE10]
    end
    if (wr_cnt_lo) begin
      count_next[7:0] = sfr_wdata_in; // [RULE11]
    end
    // capture overrides a same-cycle reload write
    if (cap_fire) begin
      reload_next = count_reg; // [RULE2]
      set_hi = 1'b1; // [RULE3]
    end
    flag_hi_next = flag_hi_reg;
    flag_lo_next = flag_lo_reg;
    low_irq_en_next = low_irq_en_reg;
    cap_en_next = cap_en_reg;
    split_next = split_reg;
    run_next = run_reg;
    xclk_next = xclk_reg;
    // bit one has no storage, so writes to it vanish
    if (wr_ctrl) begin // [RULE7]
      flag_hi_next = sfr_wdata_in[`TMR_BIT_HIGH_FLAG];
      flag_lo_next = sfr_wdata_in[`TMR_BIT_LOW_FLAG];
      low_irq_en_next = sfr_wdata_in[`TMR_BIT_LOW_IRQ_EN];
      cap_en_next = sfr_wdata_in[`TMR_BIT_CAPTURE_EN];
      split_next = sfr_wdata_in[`TMR_BIT_SPLIT];
      run_next = sfr_wdata_in[`TMR_BIT_RUN];
      xclk_next = sfr_wdata_in[`TMR_BIT_EXT_CLOCK];
    end
    flag_hi_next = flag_hi_next | set_hi; // [RULE14]
    flag_lo_next = flag_lo_next | set_lo; // [RULE14]
    irq_next = timer_irq_enable_in && // [RULE1] [RULE3]
               (flag_hi_next || (low_irq_en_next && flag_lo_next));
  end

  always_ff @(posedge clock_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      flag_hi_reg <= 1'b0;
      flag_lo_reg <= 1'b0;
      low_irq_en_reg <= 1'b0;
      cap_en_reg <= 1'b0;
      split_reg <= 1'b0;
      run_reg <= 1'b0;
      xclk_reg <= 1'b0;
      reload_reg <= `TMR_RESET_WORD; // [RULE10]
      count_reg <= `TMR_RESET_WORD;
      irq_out <= 1'b0;
    end else begin
      flag_hi_reg <= flag_hi_next;
      flag_lo_reg <= flag_lo_next;
      low_irq_en_reg <= low_irq_en_next;
      cap_en_reg <= cap_en_next;
      split_reg <= split_next;
      run_reg <= run_next;
      xclk_reg <= xclk_next;
      reload_reg <= reload_next;
      count_reg <= count_next;
      irq_out <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port and count output
  logic [7:0] rdata_next;
  logic [15:0] count_out_next;

  // read mux; unmapped addresses answer zero
  always_comb begin
    count_out_next = count_next;
    rdata_next = sfr_rdata_out;
    if (sfr_rd_in) begin
      unique case (sfr_addr_in)
        `TMR_ADDR_CONTROL: begin
          rdata_next = {flag_hi_reg, flag_lo_reg, low_irq_en_reg, cap_en_reg,
                        split_reg, run_reg, 1'b0, xclk_reg}; // [RULE7]
        end
        `TMR_ADDR_RELOAD_LOW: rdata_next = reload_reg[7:0]; // [RULE10]
        `TMR_ADDR_RELOAD_HIGH: rdata_next = reload_reg[15:8]; // [RULE10]
        `TMR_ADDR_COUNT_LOW: rdata_next = count_reg[7:0]; // [RULE11]
        default: rdata_next = `TMR_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sfr_rdata_out <= `TMR_RESET_BYTE;
      timer_count_out <= `TMR_RESET_WORD;
    end else begin
      sfr_rdata_out <= rdata_next;
      timer_count_out <= count_out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_sync_reg);

  chk_low_irq_req: assert property ( // [RULE1]
    (timer_irq_enable_in && low_irq_en_reg && flag_lo_reg && !wr_ctrl)
      |=> irq_out)
    else $error("low byte interrupt not requested");

  chk_capture_copy: assert property ( // [RULE2]
    cap_fire |=> (reload_reg == $past(count_reg)))
    else $error("capture did not copy the count");

  chk_capture_flag: assert property ( // [RULE3]
    (cap_fire && timer_irq_enable_in) |=> (flag_hi_reg && irq_out))
    else $error("capture did not raise the request");

  chk_wide_halt: assert property ( // [RULE5]
    (!split_reg && !run_reg && !wr_cnt_lo) |=> $stable(count_reg))
    else $error("16-bit count moved while halted");

  chk_split_low_runs: assert property ( // [RULE6]
    (split_reg && low_tick && !wr_cnt_lo &&
     count_reg[7:0] != `TMR_BYTE_ALL_ONES)
      |=> (count_reg[7:0] == $past(count_reg[7:0]) + 8'h01))
    else $error("split low byte did not count");

  chk_unused_bit: assert property ( // [RULE7]
    (sfr_rd_in && sfr_addr_in == `TMR_ADDR_CONTROL)
      |=> !sfr_rdata_out[`TMR_BIT_UNUSED])
    else $error("unused control bit read as one");

  chk_div12_period: assert property ( // [RULE8]
    tick12 |-> ##1 !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("system clock divider not twelve");

  chk_count_write: assert property ( // [RULE11]
    wr_cnt_lo |=> (count_reg[7:0] == $past(sfr_wdata_in)))
    else $error("low count write lost");

  chk_wide_rollover: assert property ( // [RULE12]
    (!split_reg && run_reg && low_tick && !wr_cnt_lo &&
     count_reg == `TMR_WORD_ALL_ONES)
      |=> (count_reg == $past(reload_reg) && flag_hi_reg && flag_lo_reg))
    else $error("16-bit rollover did not reload");

  chk_system_clock_select: assert property ( // [RULE13]
    (!split_reg && run_reg && low_byte_clock_select_in && !wr_cnt_lo &&
     count_reg != `TMR_WORD_ALL_ONES)
      |=> (count_reg == $past(count_reg) + 16'h0001))
    else $error("system clock select did not count");

  chk_flag_sticky: assert property ( // [RULE14]
    (flag_hi_reg && !wr_ctrl) |=> flag_hi_reg)
    else $error("high flag cleared by hardware");

  chk_split_reload: assert property ( // [RULE15]
    (split_reg && low_tick && !wr_cnt_lo &&
     count_reg[7:0] == `TMR_BYTE_ALL_ONES)
      |=> (count_reg[7:0] == $past(reload_reg[7:0]) && flag_lo_reg))
    else $error("split low byte did not reload");

  chk_no_split_capture: assert property ( // [RULE16]
    (split_reg && !wr_rl_lo && !wr_rl_hi) |=> $stable(reload_reg))
    else $error("reload changed by capture in split mode");

endmodule : split_reload_timer

// *** split_reload_timer_tb.sv ***
// self-checking testbench for the split reload timer
`timescale 1ns/1ps
`include "split_reload_timer_cfg.svh"

module split_reload_timer_tb;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observation signals
  logic clock_in;
  logic arst_n_in;
  logic [7:0] sfr_addr_in;
  logic sfr_wr_in;
  logic sfr_rd_in;
  logic [7:0] sfr_wdata_in;
  logic [7:0] sfr_rdata_out;
  logic timer_irq_enable_in;
  logic high_byte_clock_select_in;
  logic low_byte_clock_select_in;
  logic ext_osc_in;
  logic capture_comparator_in;
  logic irq_out;
  logic [15:0] timer_count_out;
  int num_errors;
  int checks_done;
  int cycles;
  logic [7:0] rd_val;
  logic [15:0] snap;
  logic [15:0] pair;

  // device under test
  split_reload_timer DUT (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out),
    .timer_irq_enable_in(timer_irq_enable_in),
    .high_byte_clock_select_in(high_byte_clock_select_in),
    .low_byte_clock_select_in(low_byte_clock_select_in),
    .ext_osc_in(ext_osc_in),
    .capture_comparator_in(capture_comparator_in),
    .irq_out(irq_out),
    .timer_count_out(timer_count_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // cycle count, external oscillator at a quarter of the clock, hang guard
  always @(posedge clock_in) begin
    cycles = cycles + 1;
    ext_osc_in <= cycles[1];
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clock_in);
    sfr_wr_in <= 1'b0;
  endtask : wr

  // read data is registered and holds until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clock_in);
    sfr_rd_in <= 1'b0;
    @(posedge clock_in);
    #1 rd_val = sfr_rdata_out;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : cyc

  task automatic rd_reload(output logic [15:0] v);
    rd(`TMR_ADDR_RELOAD_HIGH);
    v[15:8] = rd_val;
    rd(`TMR_ADDR_RELOAD_LOW);
    v[7:0] = rd_val;
  endtask : rd_reload

  // comparator held high for a few cycles, then settled
  task automatic pulse_cmp();
    @(posedge clock_in);
    capture_comparator_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    capture_comparator_in <= 1'b0;
    cyc(6);
  endtask : pulse_cmp

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset();
    logic [7:0] addrs [5] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC};
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk({8'h00, rd_val}, 16'h0000);
    end
    chk(timer_count_out, 16'h0000);
    wr(`TMR_ADDR_CONTROL, 8'h02);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val}, 16'h0000);
    wr(`TMR_ADDR_COUNT_LOW, 8'h5A);
    rd(`TMR_ADDR_COUNT_LOW);
    chk({8'h00, rd_val}, 16'h005A);
    wr(`TMR_ADDR_RELOAD_LOW, 8'hA5);
    rd(`TMR_ADDR_RELOAD_LOW);
    chk({8'h00, rd_val}, 16'h00A5);
    $display("test reset and access done");
  endtask : test_reset

  task automatic test_run_gate();
    snap = timer_count_out;
    cyc(20);
    chk(timer_count_out, snap);
    wr(`TMR_ADDR_CONTROL, 8'h04);
    cyc(20);
    chk({15'h0, timer_count_out != snap}, 16'h0001);
    $display("test run gate done");
  endtask : test_run_gate

  // split phase parks the high byte at all ones, then a wide rollover
  task automatic test_rollover();
    int n;
    wr(`TMR_ADDR_RELOAD_HIGH, 8'hFF);
    wr(`TMR_ADDR_CONTROL, 8'h0C);
    cyc(270);
    chk({8'h00, timer_count_out[15:8]}, 16'h00FF);
    wr(`TMR_ADDR_COUNT_LOW, 8'h00);
    wr(`TMR_ADDR_CONTROL, 8'h04);
    wr(`TMR_ADDR_RELOAD_LOW, 8'h34);
    wr(`TMR_ADDR_RELOAD_HIGH, 8'h12);
    wr(`TMR_ADDR_COUNT_LOW, 8'hF0);
    n = 0;
    while (timer_count_out[15:8] !== 8'h12 && n < 300) begin
      cyc(1);
      n++;
    end
    chk({8'h00, timer_count_out[15:8]}, 16'h0012);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val}, 16'h00C4);
    chk({15'h0, irq_out}, 16'h0001);
    cyc(20);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val}, 16'h00C4);
    $display("test wide rollover done");
  endtask : test_rollover

  task automatic test_low_irq();
    wr(`TMR_ADDR_CONTROL, 8'h04);
    wr(`TMR_ADDR_COUNT_LOW, 8'hFE);
    cyc(6);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val}, 16'h0044);
    chk({15'h0, irq_out}, 16'h0000);
    wr(`TMR_ADDR_CONTROL, 8'h24);
    wr(`TMR_ADDR_COUNT_LOW, 8'hFE);
    cyc(6);
    chk({15'h0, irq_out}, 16'h0001);
    @(posedge clock_in);
    timer_irq_enable_in <= 1'b0;
    cyc(3);
    chk({15'h0, irq_out}, 16'h0000);
    @(posedge clock_in);
    timer_irq_enable_in <= 1'b1;
    $display("test low byte interrupt done");
  endtask : test_low_irq

  task automatic test_split();
    wr(`TMR_ADDR_RELOAD_LOW, 8'h80);
    wr(`TMR_ADDR_CONTROL, 8'h08);
    snap = timer_count_out;
    wr(`TMR_ADDR_COUNT_LOW, 8'hFE);
    cyc(10);
    chk({8'h00, timer_count_out[15:8]}, {8'h00, snap[15:8]});
    rd(`TMR_ADDR_COUNT_LOW);
    chk({15'h0, rd_val >= 8'h80 && rd_val < 8'hA0}, 16'h0001);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val}, 16'h0048);
    $display("test split mode done");
  endtask : test_split

  task automatic test_prescale();
    @(posedge clock_in);
    low_byte_clock_select_in <= 1'b0;
    wr(`TMR_ADDR_CONTROL, 8'h04);
    cyc(2);
    snap = timer_count_out;
    cyc(120);
    chk(timer_count_out - snap, 16'h000A);
    wr(`TMR_ADDR_CONTROL, 8'h05);
    cyc(40);
    snap = timer_count_out;
    cyc(320);
    chk(timer_count_out - snap, 16'h000A);
    @(posedge clock_in);
    low_byte_clock_select_in <= 1'b1;
    $display("test prescalers done");
  endtask : test_prescale

  task automatic test_capture();
    wr(`TMR_ADDR_CONTROL, 8'h14);
    cyc(5);
    snap = timer_count_out;
    pulse_cmp();
    rd_reload(pair);
    // two sync flops and the edge stage: count seen three cycles on
    chk(pair - snap, 16'h0003);
    rd(`TMR_ADDR_CONTROL);
    chk({8'h00, rd_val & 8'h80}, 16'h0080);
    chk({15'h0, irq_out}, 16'h0001);
    wr(`TMR_ADDR_CONTROL, 8'h1C);
    rd_reload(snap);
    pulse_cmp();
    rd_reload(pair);
    chk(pair, snap);
    $display("test capture done");
  endtask : test_capture

  ////////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    arst_n_in = 1'b0;
    sfr_addr_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_rd_in = 1'b0;
    sfr_wdata_in = 8'h00;
    timer_irq_enable_in = 1'b1;
    high_byte_clock_select_in = 1'b1;
    low_byte_clock_select_in = 1'b1;
    ext_osc_in = 1'b0;
    capture_comparator_in = 1'b0;
    repeat (12) @(posedge clock_in);
    arst_n_in <= 1'b1;
    cyc(3);
    test_reset();
    test_run_gate();
    test_rollover();
    test_low_irq();
    test_split();
    test_prescale();
    test_capture();
    stop_test();
  end

endmodule : split_reload_timer_tb
